// >>> include/arwc_pkg.sv
// Package: register map, field layout, reset values and carrier types of the result window comparator
package arwc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL    = 8'h00;
  localparam logic [7:0] OFF_CHAN_LOW   = 8'h04;
  localparam logic [7:0] OFF_CHAN_HIGH  = 8'h08;
  localparam logic [7:0] OFF_LOW_THR    = 8'h0C;
  localparam logic [7:0] OFF_HIGH_THR   = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h18;

  // Control register field positions
  localparam int POS_BELOW_LOW   = 0;
  localparam int POS_ABOVE_LOW   = 1;
  localparam int POS_BELOW_HIGH  = 2;
  localparam int POS_ABOVE_HIGH  = 3;
  localparam int POS_INSIDE      = 4;
  localparam int POS_EVENT_FLAG  = 5;
  localparam int POS_IRQ_ENABLE  = 6;
  localparam int POS_COMP_ON     = 7;
  localparam int POS_SOURCE_LSB  = 8;

  // Reset values
  localparam logic [7:0]  RST_CONTROL = 8'h00;
  localparam logic [15:0] RST_CHAN    = 16'h0000;
  localparam logic [15:0] RST_THR     = 16'h0000;
  localparam logic [4:0]  RST_SOURCE  = 5'h00;
  localparam logic [1:0]  RST_IRQ     = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One conversion result delivered by a converter core
  typedef struct packed {
    logic        valid;
    logic [4:0]  channel;
    logic [15:0] value;
  } arwc_result_s;

  // Writable part of the control register
  typedef struct packed {
    logic comp_on;
    logic irq_enable;
    logic inside_window_sel;
    logic at_or_above_high_sel;
    logic below_high_sel;
    logic at_or_above_low_sel;
    logic below_low_sel;
  } arwc_ctrl_s;

endpackage : arwc_pkg

// >>> hw/arwc_match.sv
// Combinational window match of one conversion result against the threshold pair
`timescale 1ns/1ps
module arwc_match (
  input  wire arwc_pkg::arwc_result_s result,
  input  wire arwc_pkg::arwc_ctrl_s   ctrl,
  input  wire logic [31:0]            channel_use_mask,
  input  wire logic [15:0]            low_threshold,
  input  wire logic [15:0]            high_threshold,
  output wire logic                   hit
);
  import arwc_pkg::*;

  // Unsigned compares; a signed result format would need signed thresholds
  wire logic below_low  = result.value < low_threshold;
  wire logic below_high = result.value < high_threshold;
  wire logic used       = channel_use_mask[result.channel];
  wire logic any_cond;

  // Selected conditions are alternatives
  assign any_cond = (ctrl.below_low_sel        &  below_low)
                  | (ctrl.at_or_above_low_sel  & ~below_low)
                  | (ctrl.below_high_sel       &  below_high)
                  | (ctrl.at_or_above_high_sel & ~below_high)
                  | (ctrl.inside_window_sel    & ~below_low & below_high);
  assign hit = result.valid & used & ctrl.comp_on & any_cond;

endmodule : arwc_match

// >>> hw/arwc_flag.sv
// Sticky flag where a set wins over a same-cycle clear
`timescale 1ns/1ps
module arwc_flag (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);
  import arwc_pkg::*;

  wire logic next_flag = set | (flag & ~clear);

  // Events are never lost to a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : arwc_flag

// >>> hw/arwc_top.sv
// Result window comparator with AXI4-Lite registers and interrupt outputs
// How it works
// - On each event the number of the source input is stored in a 5-bit field, 11111 for input 31 down to 00000.
// - Clearing comparator_on stops event detection and clears the sticky event flag.
// - With irq_enable set each event sets both status bits and raises the individual and the common interrupt where irq_mask allows; clear, neither is raised.
// - A software read of the control word holding event_source_index clears the sticky event flag.
// - The event flag is set by every event and stays set until the next read of the source index or until comparator_on is cleared.
// - inside_window_sel signals an event when low_threshold <= result < high_threshold.
// - at_or_above_high_sel signals an event when result >= high_threshold.
// - below_high_sel signals an event when result < high_threshold.
// - at_or_above_low_sel signals an event when result >= low_threshold.
// - below_low_sel signals an event when result < low_threshold.
// - Control bits 15 to 13 ignore writes and read as zero.
// - Each bit of channel_use_mask admits results of its input channel; a zero bit excludes it.
`timescale 1ns/1ps
module arwc_top (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire arwc_pkg::arwc_result_s result,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        event_irq,
  output logic                        common_irq,
  output logic                        irq
);
  import arwc_pkg::*;

  // Register state
  arwc_ctrl_s  ctrl;
  logic [31:0] channel_use_mask;
  logic [15:0] low_threshold;
  logic [15:0] high_threshold;
  logic [4:0]  event_source_index;
  logic [1:0]  irq_mask;
  logic [1:0]  irq_status;
  logic        event_flag;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // Byte-lane merge, used for every writable register except the write-one-to-clear status
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // Comparator datapath
  wire logic hit;
  arwc_match u_match (
    .result           (result),
    .ctrl             (ctrl),
    .channel_use_mask (channel_use_mask),
    .low_threshold    (low_threshold),
    .high_threshold   (high_threshold),
    .hit              (hit)
  );

  // Write channel: address and data are taken in either order, each held until both arrive
  wire logic aw_take  = s_axi_awvalid & s_axi_awready;
  wire logic w_take   = s_axi_wvalid & s_axi_wready;
  wire logic wr_go    = aw_held & w_held & ~s_axi_bvalid;
  wire logic wr_ctrl  = wr_go & (aw_addr == OFF_CONTROL);
  wire logic wr_cl    = wr_go & (aw_addr == OFF_CHAN_LOW);
  wire logic wr_ch    = wr_go & (aw_addr == OFF_CHAN_HIGH);
  wire logic wr_lo    = wr_go & (aw_addr == OFF_LOW_THR);
  wire logic wr_hi    = wr_go & (aw_addr == OFF_HIGH_THR);
  wire logic wr_st    = wr_go & (aw_addr == OFF_IRQ_STATUS);
  wire logic wr_mk    = wr_go & (aw_addr == OFF_IRQ_MASK);
  wire logic wr_known = wr_ctrl | wr_cl | wr_ch | wr_lo | wr_hi | wr_st | wr_mk;

  // Read channel: answer one cycle after the address is taken
  wire logic ar_take  = s_axi_arvalid & s_axi_arready;
  wire logic rd_ctrl  = ar_take & (s_axi_araddr == OFF_CONTROL);
  wire logic [31:0] ctrl_word = {16'h0000, 3'h0, event_source_index, ctrl.comp_on, ctrl.irq_enable,
                                 event_flag, ctrl.inside_window_sel, ctrl.at_or_above_high_sel,
                                 ctrl.below_high_sel, ctrl.at_or_above_low_sel, ctrl.below_low_sel};
  logic [31:0] rd_word;
  logic        rd_known;
  always_comb begin
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      OFF_CONTROL:    rd_word = ctrl_word;
      OFF_CHAN_LOW:   rd_word = {16'h0000, channel_use_mask[15:0]};
      OFF_CHAN_HIGH:  rd_word = {16'h0000, channel_use_mask[31:16]};
      OFF_LOW_THR:    rd_word = {16'h0000, low_threshold};
      OFF_HIGH_THR:   rd_word = {16'h0000, high_threshold};
      OFF_IRQ_STATUS: rd_word = {30'h0, irq_status};
      OFF_IRQ_MASK:   rd_word = {30'h0, irq_mask};
      default: begin
        rd_word  = 32'h00000000;
        rd_known = 1'b0;
      end
    endcase
  end

  // Merged write values
  wire logic [31:0] ctrl_m = merge(ctrl_word, w_data, w_strb);
  wire logic [31:0] cl_m   = merge({16'h0000, channel_use_mask[15:0]}, w_data, w_strb);
  wire logic [31:0] ch_m   = merge({16'h0000, channel_use_mask[31:16]}, w_data, w_strb);
  wire logic [31:0] lo_m   = merge({16'h0000, low_threshold}, w_data, w_strb);
  wire logic [31:0] hi_m   = merge({16'h0000, high_threshold}, w_data, w_strb);
  wire logic [31:0] mk_m   = merge({30'h0, irq_mask}, w_data, w_strb);
  wire logic [1:0]  st_clr = (wr_st & w_strb[0]) ? w_data[1:0] : 2'h0;

  // Sticky event flag: cleared by reading the source index or by switching off
  wire logic off_now  = ~ctrl.comp_on | (wr_ctrl & ~ctrl_m[POS_COMP_ON]);
  wire logic flag_clr = rd_ctrl | off_now;
  wire logic flag_set = hit & ~(wr_ctrl & ~ctrl_m[POS_COMP_ON]);
  arwc_flag u_flag (
    .clock (clock),
    .rst   (rst),
    .set   (flag_set),
    .clear (flag_clr),
    .flag  (event_flag)
  );

  // Interrupt events: bit 0 is a comparator event with irq_enable, bit 1 the same event for the common line
  wire logic       irq_event = flag_set & ctrl.irq_enable;
  wire logic [1:0] next_irq_status = {2{irq_event}} | (irq_status & ~st_clr);

  // Bus handshake state
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held       <= 1'b1;
        aw_addr       <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;  // Unmapped writes are refused
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read answer; arready drops while a read answer is pending
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Writable registers; bits 15..8 and the flag bit of control are not stored
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl             <= arwc_ctrl_s'(RST_CONTROL[6:0]);
      channel_use_mask <= {RST_CHAN, RST_CHAN};
      low_threshold    <= RST_THR;
      high_threshold   <= RST_THR;
      irq_mask         <= RST_IRQ;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {ctrl_m[POS_COMP_ON], ctrl_m[POS_IRQ_ENABLE], ctrl_m[POS_INSIDE:POS_BELOW_LOW]};
      end
      if (wr_cl) begin
        channel_use_mask[15:0] <= cl_m[15:0];
      end
      if (wr_ch) begin
        channel_use_mask[31:16] <= ch_m[15:0];
      end
      if (wr_lo) begin
        low_threshold <= lo_m[15:0];
      end
      if (wr_hi) begin
        high_threshold <= hi_m[15:0];
      end
      if (wr_mk) begin
        irq_mask <= mk_m[1:0];
      end
    end
  end

  // Source index capture, status and interrupt outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      event_source_index <= RST_SOURCE;
      irq_status         <= RST_IRQ;
      event_irq          <= 1'b0;
      common_irq         <= 1'b0;
      irq                <= 1'b0;
    end else begin
      if (flag_set) begin
        event_source_index <= result.channel;
      end
      irq_status <= next_irq_status;           // Set wins over write-one-to-clear
      event_irq  <= next_irq_status[0] & irq_mask[0];
      common_irq <= next_irq_status[1] & irq_mask[1];
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // Silence unused bits of the merged control word and of the other merged write values
  wire logic unused_ok = &{1'b0, ctrl_m[31:8], ctrl_m[POS_EVENT_FLAG], cl_m[31:16], ch_m[31:16], lo_m[31:16],
                           hi_m[31:16], mk_m[31:2]};

endmodule : arwc_top

// >>> tb/arwc_properties.sv
// Checker: port-level properties of the result window comparator
`timescale 1ns/1ps
module arwc_properties (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire arwc_pkg::arwc_result_s result,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic [7:0]             s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic                   event_irq,
  input wire logic                   common_irq,
  input wire logic                   irq
);
  import arwc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic ctl_rd;
  logic quiet;
  assign ctl_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CONTROL;
  // Quiet while no result arrived since the last control read; a result wins
  always_ff @(posedge clock) begin
    if (rst) quiet <= 1'b1;
    else if (result.valid) quiet <= 1'b0;
    else if (ctl_rd) quiet <= 1'b1;
  end
  sequence ctl_read_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CONTROL;
  endsequence
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ready_low_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFF_IRQ_MASK
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  upper_zero_a: assert property (ctl_read_s |=> s_axi_rdata[31:13] == 19'h0)
    else $error("control upper bits not zero");
  flag_clear_a: assert property (ctl_rd && quiet |=> !s_axi_rdata[5])
    else $error("event flag set without a result");
  irq_cause_a: assert property ($rose(event_irq) && !s_axi_bvalid && !$past(s_axi_bvalid)
    |-> $past(result.valid)) else $error("event interrupt without a result");
  irq_join_a: assert property (event_irq || common_irq |-> irq)
    else $error("summary interrupt missing");
endmodule : arwc_properties
bind arwc_top arwc_properties i_arwc_properties (.clock(clock), .rst(rst), .result(result),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .event_irq(event_irq), .common_irq(common_irq), .irq(irq));

// >>> tb/arwc_source.sv
// Partner model: converter core that delivers conversion results
`timescale 1ns/1ps
module arwc_source (
  input wire logic              clock,
  output arwc_pkg::arwc_result_s result
);
  import arwc_pkg::*;
  initial result = '0;
  // One result after gap idle cycles; idle lines carry inverted data so stale values never pass
  task automatic send(input logic [4:0] ch, input logic [15:0] v, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    result <= '{valid: 1'b1, channel: ch, value: v};
    @(posedge clock);
    result <= '{valid: 1'b0, channel: ~ch, value: ~v};
  endtask : send
endmodule : arwc_source

// >>> tb/adc_result_window_comparator_bench.sv
// Bench: random and corner-case checks of the result window comparator
`timescale 1ns/1ps
module adc_result_window_comparator_bench;
  import arwc_pkg::*;
  logic clock, rst, event_irq, common_irq, irq;
  arwc_result_s result;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int bad_count, checks;
  arwc_top i_arwc_top (.clock(clock), .rst(rst), .result(result), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .event_irq(event_irq), .common_irq(common_irq), .irq(irq));
  arwc_source i_arwc_source (.clock(clock), .result(result));
  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic final_report;
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // A wait that used up its bound ends the run
  task automatic bound(input int n);
    if (n >= 50) begin
      bad_count++;
      final_report();
    end
  endtask : bound
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
    bound(n);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", er, s_axi_rresp);
    bound(n);
  endtask : rd
  // Expected event: any selected condition, admitted channel, comparator on
  function automatic logic hit_of(input logic [4:0] s, input logic on, input logic [31:0] m,
      input logic [4:0] ch, input logic [15:0] v, lo, hi);
    return on && m[ch] && (s[0] && v < lo || s[1] && v >= lo || s[2] && v < hi
      || s[3] && v >= hi || s[4] && v >= lo && v < hi);
  endfunction : hit_of
  // Main sequence: reset values, refusals, then random windows with edge values
  initial begin
    logic [31:0] d, m, c;
    logic [15:0] lo, hi, v;
    logic [4:0] ch, src;
    logic [1:0] mk;
    logic h, f;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    bad_count = 0;
    checks = 0;
    src = 5'h00;
    void'($urandom(66));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a <= 8'h18; a += 4) begin
      rd(a[7:0], d, RESP_OKAY);
      chk("reset value", 32'h0, d);
    end
    rd(8'h1C, d, RESP_SLVERR);
    chk("unmapped read", 32'h0, d);
    wr(8'h20, 32'hFFFFFFFF, RESP_SLVERR);
    for (int k = 0; k < 60; k++) begin
      lo = 16'($urandom);
      hi = 16'($urandom);
      m = $urandom;
      c = $urandom;
      ch = 5'($urandom);
      mk = (k % 4 == 2) ? 2'h1 : 2'h3;
      c[7] = (k % 4 != 0);
      c[6] = (k % 3 != 0);
      if (k < 5) c[4:0] = 5'h01 << k;
      case (k % 5)
        0: v = lo;
        1: v = hi;
        2: v = lo - 16'h1;
        3: v = hi - 16'h1;
        default: v = 16'($urandom);
      endcase
      wr(OFF_LOW_THR, {16'h0, lo}, RESP_OKAY);
      wr(OFF_HIGH_THR, {16'h0, hi}, RESP_OKAY);
      wr(OFF_CHAN_LOW, {16'h0, m[15:0]}, RESP_OKAY);
      wr(OFF_CHAN_HIGH, {16'h0, m[31:16]}, RESP_OKAY);
      wr(OFF_IRQ_MASK, {30'h0, mk}, RESP_OKAY);
      wr(OFF_IRQ_STATUS, 32'h3, RESP_OKAY);
      wr(OFF_CONTROL, c, RESP_OKAY);
      chk("irq cleared", 1'b0, irq);
      h = hit_of(c[4:0], c[7], m, ch, v, lo, hi);
      i_arwc_source.send(ch, v, k % 3);
      @(negedge clock);
      chk("event_irq", h && c[6] && mk[0], event_irq);
      chk("common_irq", h && c[6] && mk[1], common_irq);
      chk("irq", h && c[6], irq);
      f = h;
      if (h) src = ch;
      // Switching off must drop a pending event flag
      if (h && k % 6 == 1) begin
        c[7] = 1'b0;
        wr(OFF_CONTROL, c, RESP_OKAY);
        f = 1'b0;
      end
      rd(OFF_CONTROL, d, RESP_OKAY);
      chk("control", {19'h0, src, c[7:6], f, c[4:0]}, d);
      rd(OFF_CONTROL, d, RESP_OKAY);
      chk("event flag", 1'b0, d[5]);
    end
    final_report();
  end
endmodule : adc_result_window_comparator_bench
